// >>> core/ams_mode_sequencer.sv
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`default_nettype none
module ams_mode_sequencer
  import ams_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clock_input_pin,
  input wire logic crystal_mode,
  output logic clock_output_pin,
  output logic clock_output_oe,
  output logic rdy_n,
  input wire logic [23:0] conv_sample,
  input wire logic conv_over_hi,
  input wire logic conv_over_lo,
  output logic analog_power_down,
  output logic [1:0] mux_channel,
  output logic [1:0] input_source,
  output logic cont_read_active
);
  typedef enum {ST_IDLE, ST_CONVERT, ST_CALIBRATE, ST_STANDBY} ams_state_t;

  // Pin synchronisers: bit 0 clock pin, bit 1 crystal strap
  logic [1:0] pin_raw;
  logic [1:0] s1_q, s2_q, s3_q, filt_q;
  assign pin_raw = {crystal_mode, clock_input_pin};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          filt_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            filt_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  ams_mode_t mode_q;
  ams_state_t state_q;
  logic [1:0] cur_ch_q;
  logic [15:0] tick_cnt_q;
  logic [3:0] ch_enable_q;
  logic [3:0] ready_q;
  logic [15:0] conv_time_q [NUM_CH];
  ams_chan_t chan_q [NUM_CH];
  logic [23:0] self_zcal_q, self_fcal_q;
  logic [23:0] ch_zcal_q [NUM_CH];
  logic [23:0] ch_fcal_q [NUM_CH];

  // Crystal stops when its output pin is released; external clock keeps going
  wire mclk_rise = (s2_q[0] == s3_q[0]) & s3_q[0] & ~filt_q[0];
  wire clock_stopped = filt_q[1] & mode_q.clock_output_disable;
  wire mclk_tick = mclk_rise & ~clock_stopped;
  wire [15:0] tick_next = tick_cnt_q + 16'h0001;
  // Idle and standby never count, so a short time cannot end them
  wire op_busy = (state_q == ST_CONVERT) | (state_q == ST_CALIBRATE);
  wire op_done = mclk_tick & op_busy & (tick_next >= conv_time_q[cur_ch_q]);
  wire conv_done = op_done & (state_q == ST_CONVERT);
  wire cal_done = op_done & (state_q == ST_CALIBRATE);

  // Write channel
  logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q;
  logic [AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  wire aw_hold_d = (aw_hold_q | aw_take) & ~wr_fire;
  wire w_hold_d = (w_hold_q | w_take) & ~wr_fire;

  wire [3:0] wr_rgn = awaddr_q[7:4];
  wire [1:0] wr_ch = awaddr_q[3:2];
  wire wr_mode_hit = (awaddr_q >= ADDR_MODE_FIRST) &
                     (awaddr_q <= ADDR_MODE_LAST) & (awaddr_q[1:0] == 2'b00);
  wire mode_wr = wr_fire & wr_mode_hit & wstrb_q[0];
  wire en_wr = wr_fire & (awaddr_q == ADDR_CH_ENABLE) & wstrb_q[0];
  wire ct_wr = wr_fire & (wr_rgn == RGN_CONV_TIME) & (awaddr_q[1:0] == 2'b00);
  wire wr_mapped = wr_mode_hit | (awaddr_q == ADDR_CH_ENABLE) |
                   ((wr_rgn == RGN_CONV_TIME) & (awaddr_q[1:0] == 2'b00));
  wire ams_mode_t mode_wr_val = ams_mode_t'(wdata_q[7:0]);
  // Channel is the index's low bits, i.e. byte address bits 3:2
  wire [1:0] mode_wr_ch = awaddr_q[3:2];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready_q <= ~aw_hold_d;
      wready_q <= ~w_hold_d;
      bvalid_q <= wr_fire | (bvalid_q & ~s_axi_bready);
      if (wr_fire) begin
        bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // Read channel
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire ar_take = s_axi_arvalid & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  wire [3:0] rd_rgn = s_axi_araddr[7:4];
  wire [1:0] rd_ch = s_axi_araddr[3:2];
  wire rd_aligned = s_axi_araddr[1:0] == 2'b00;
  wire data_rd = ar_take & (rd_rgn == RGN_CH_DATA) & rd_aligned;
  wire with_status = mode_q.dump | mode_q.cont_rd;
  wire [31:0] rd_packed = chan_q[rd_ch];

  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok = rd_aligned;
    case (rd_rgn)
      4'h0: begin
        if (s_axi_araddr == ADDR_STATUS) begin
          rd_val = {24'h000000, mode_q.op, state_q != ST_IDLE, ready_q};
        end else if (s_axi_araddr == ADDR_CH_ENABLE) begin
          rd_val = {28'h0000000, ch_enable_q};
        end else begin
          rd_ok = 1'b0;
        end
      end
      RGN_CONV_TIME: rd_val = {16'h0000, conv_time_q[rd_ch]};
      RGN_CH_STATUS: begin
        rd_val = with_status ? rd_packed : {24'h000000, rd_packed[31:24]};
      end
      RGN_CH_DATA: begin
        rd_val = with_status ? rd_packed : {8'h00, rd_packed[23:0]};
      end
      4'h4: begin
        if (s_axi_araddr == ADDR_SELF_ZCAL) begin
          rd_val = {8'h00, self_zcal_q};
        end else if (s_axi_araddr == ADDR_SELF_FCAL) begin
          rd_val = {8'h00, self_fcal_q};
        end else begin
          rd_ok = 1'b0;
        end
      end
      RGN_CH_ZCAL: rd_val = {8'h00, ch_zcal_q[rd_ch]};
      RGN_CH_FCAL: rd_val = {8'h00, ch_fcal_q[rd_ch]};
      4'he, 4'hf: begin
        // Other mode indices are write-only and read as zero
        if (s_axi_araddr == ADDR_MODE_RD) begin
          rd_val = {24'h000000, mode_q};
        end
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_val;
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Result formatting
  wire over_range = conv_over_hi | conv_over_lo;
  wire [23:0] width_mask = mode_q.wide ? 24'hffffff : 24'h00ffff;
  wire [23:0] sized = mode_q.wide ? conv_sample : {8'h00, conv_sample[23:8]};
  wire [23:0] clamped = conv_over_hi ? width_mask : 24'h000000;
  wire [23:0] result = (mode_q.clamp & over_range) ? clamped : sized;

  function automatic logic [1:0] next_enabled(input logic [1:0] cur,
                                               input logic [3:0] en);
    logic [1:0] cand;
    logic found;
    next_enabled = cur;
    found = 1'b0;
    for (int i = 1; i <= NUM_CH; i++) begin
      cand = cur + 2'(i);
      if (en[cand] && !found) begin
        next_enabled = cand;
        found = 1'b1;
      end
    end
  endfunction

  function automatic ams_state_t state_for(input ams_op_t op);
    case (op)
      OP_IDLE: state_for = ST_IDLE;
      OP_CONT, OP_SINGLE: state_for = ST_CONVERT;
      OP_STANDBY: state_for = ST_STANDBY;
      default: state_for = ST_CALIBRATE;
    endcase
  endfunction

  // Sequencer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q <= ams_mode_t'(MODE_RESET);
      state_q <= ST_IDLE;
      cur_ch_q <= 2'b00;
      tick_cnt_q <= 16'h0000;
    end else if (mode_wr) begin
      mode_q <= mode_wr_val;
      state_q <= state_for(mode_wr_val.op);
      cur_ch_q <= mode_wr_ch;
      tick_cnt_q <= 16'h0000;
    end else if (conv_done && mode_q.op == OP_CONT) begin
      cur_ch_q <= next_enabled(cur_ch_q, ch_enable_q);
      tick_cnt_q <= 16'h0000;
    end else if (op_done) begin
      mode_q.op <= OP_IDLE;
      state_q <= ST_IDLE;
      tick_cnt_q <= 16'h0000;
    end else if (mclk_tick && state_q != ST_IDLE && state_q != ST_STANDBY) begin
      tick_cnt_q <= tick_next;
    end
  end

  // Ready bits: a completion beats a data-read clear in the same cycle
  logic [3:0] ready_d;
  always_comb begin
    ready_d = ready_q;
    if (data_rd) begin
      ready_d[rd_ch] = 1'b0;
    end
    if (conv_done) begin
      ready_d[cur_ch_q] = 1'b1;
    end
    if (cal_done) begin
      ready_d = 4'hf;
    end
    if (mode_wr) begin
      ready_d = 4'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ready_q <= 4'h0;
      rdy_n <= 1'b1;
    end else begin
      ready_q <= ready_d;
      rdy_n <= ~|ready_d;
    end
  end

  // Channel results and calibration store
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chan
      wire hit = cur_ch_q == 2'(g);
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          chan_q[g] <= '0;
          conv_time_q[g] <= CONV_TIME_RESET;
          ch_zcal_q[g] <= CAL_RESET;
          ch_fcal_q[g] <= CAL_RESET;
        end else begin
          if (ct_wr && wr_ch == 2'(g)) begin
            if (wstrb_q[0]) conv_time_q[g][7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) conv_time_q[g][15:8] <= wdata_q[15:8];
          end
          if (conv_done && hit) begin
            chan_q[g].data <= result;
            chan_q[g].status <= '{rdy: 1'b1, ovr: over_range,
                                  zero: 4'h0, ch: 2'(g)};
          end else if (ready_d[g] != chan_q[g].status.rdy) begin
            chan_q[g].status.rdy <= ready_d[g];
          end
          if (cal_done && hit && mode_q.op == OP_ZS_SYS) begin
            ch_zcal_q[g] <= conv_sample;
          end
          if (cal_done && hit && mode_q.op == OP_FS_SYS) begin
            ch_fcal_q[g] <= conv_sample;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      self_zcal_q <= CAL_RESET;
      self_fcal_q <= CAL_RESET;
      ch_enable_q <= CH_ENABLE_RESET;
    end else begin
      if (cal_done && mode_q.op == OP_ZS_SELF) begin
        self_zcal_q <= conv_sample;
      end
      if (cal_done && mode_q.op == OP_FS_SELF) begin
        self_fcal_q <= conv_sample;
      end
      if (en_wr) begin
        ch_enable_q <= wdata_q[3:0];
      end
    end
  end

  // Pin and analog control outputs
  wire [1:0] src_d = (state_q == ST_CALIBRATE && mode_q.op == OP_ZS_SELF) ?
                     SRC_SHORTED :
                     (state_q == ST_CALIBRATE && mode_q.op == OP_FS_SELF) ?
                     SRC_FULL_REF : SRC_CHANNEL;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clock_output_pin <= 1'b0;
      clock_output_oe <= 1'b0;
      analog_power_down <= 1'b0;
      mux_channel <= 2'b00;
      input_source <= SRC_CHANNEL;
      cont_read_active <= 1'b0;
    end else begin
      // Standby does not touch the clock output
      clock_output_pin <= filt_q[0] & ~mode_q.clock_output_disable;
      clock_output_oe <= ~mode_q.clock_output_disable;
      analog_power_down <= state_q == ST_STANDBY;
      mux_channel <= cur_ch_q;
      input_source <= src_d;
      cont_read_active <= mode_q.cont_rd;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule
`default_nettype wire

// >>> core/ams_pkg.sv
// Overview of operation
// - Clock-output-disable set: stop driving master clock out, pin goes high impedance.
// - External clock: conversions continue normally regardless of clock-output-disable.
// - Crystal plus clock-output-disable: device clock stops, no conversions; bus stays usable.
// - Status-with-data clear: channel status and data are read separately.
// - Status-with-data set: either read returns status byte then channel data.
// - Continuous read always returns status then data, whatever status-with-data says.
// - Continuous-readout bit set enters continuous read operation.
// - Data-width bit: 1 gives 24-bit channel data, 0 gives 16-bit.
// - Saturate set and input out of range: data forced to all zeros or ones.
// - Saturate clear: store unclamped result even when out of range.
// - Idle after reset; back to idle after each calibration and single conversion.
// - Continuous: convert channel, update data/status, set ready, go to next enabled.
// - Continuous cycles enabled channels until new mode or reset; period sums times.
// - Single done: update channel, set ready, ready pin low, clear operation, idle.
// - Single conversion runs even when the channel is disabled.
// - Standby powers down converter and buffer; bus and clock output unaffected.
// - Zero self-calibration on shorted inputs updates converter zero register, then idle.
// - Full self-calibration on internal full scale updates converter full register, idle.
// - Zero system calibration updates selected channel zero register, all ready, idle.
// - Full system calibration updates selected channel full register, all ready, idle.
// - Mode write clears status, raises ready pin, aborts, starts the new mode.
// - Mode written at indices 0x38 to 0x3F, read at 0x38; low bits pick channel.
// - Operation codes in bits 7 to 5 ascend: idle through full system calibration.
`default_nettype none
package ams_pkg;
  localparam int NUM_CH = 4;
  localparam int AW = 8;

  // Mode register indices; byte address is four times the index
  localparam logic [7:0] MODE_IDX_FIRST = 8'h38;
  localparam logic [7:0] MODE_IDX_LAST = 8'h3f;
  localparam logic [7:0] ADDR_MODE_RD = 8'he0;
  localparam logic [7:0] ADDR_MODE_FIRST = 8'he0;
  localparam logic [7:0] ADDR_MODE_LAST = 8'hfc;

  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CH_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_SELF_ZCAL = 8'h40;
  localparam logic [7:0] ADDR_SELF_FCAL = 8'h44;
  localparam logic [3:0] RGN_CONV_TIME = 4'h1;
  localparam logic [3:0] RGN_CH_STATUS = 4'h2;
  localparam logic [3:0] RGN_CH_DATA = 4'h3;
  localparam logic [3:0] RGN_CH_ZCAL = 4'h5;
  localparam logic [3:0] RGN_CH_FCAL = 4'h6;

  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [3:0] CH_ENABLE_RESET = 4'h1;
  localparam logic [15:0] CONV_TIME_RESET = 16'h0100;
  localparam logic [23:0] CAL_RESET = 24'h000000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] SRC_CHANNEL = 2'h0;
  localparam logic [1:0] SRC_SHORTED = 2'h1;
  localparam logic [1:0] SRC_FULL_REF = 2'h2;

  typedef enum logic [2:0] {
    OP_IDLE, OP_CONT, OP_SINGLE, OP_STANDBY,
    OP_ZS_SELF, OP_FS_SELF, OP_ZS_SYS, OP_FS_SYS
  } ams_op_t;

  typedef struct packed {
    ams_op_t op;
    logic clock_output_disable;
    logic dump;
    logic cont_rd;
    logic wide;
    logic clamp;
  } ams_mode_t;

  typedef struct packed {
    logic rdy;
    logic ovr;
    logic [3:0] zero;
    logic [1:0] ch;
  } ams_ch_status_t;

  typedef struct packed {
    ams_ch_status_t status;
    logic [23:0] data;
  } ams_chan_t;
endpackage
`default_nettype wire

// >>> tb/ams_checker.sv
`default_nettype none
module ams_checker
  import ams_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clock_output_pin,
  input wire logic clock_output_oe,
  input wire logic rdy_n,
  input wire logic analog_power_down,
  input wire logic cont_read_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic am_q;
  logic ws_q;
  logic [7:0] wd_q;
  // Remember the last mode write so its effects can be tied to it
  always_ff @(posedge clk_sys) begin
    if (s_axi_awvalid && s_axi_awready) begin
      am_q <= s_axi_awaddr[7:5] == 3'h7 && s_axi_awaddr[1:0] == 2'h0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      ws_q <= s_axi_wstrb[0];
      wd_q <= s_axi_wdata[7:0];
    end
  end
  sequence mode_wr;
    $rose(s_axi_bvalid) && am_q && ws_q;
  endsequence
  clkout_off_a: assert property (mode_wr |-> ##[0:2]
    clock_output_oe == !wd_q[4]) else $error("clock output enable wrong");
  pin_quiet_a: assert property (!clock_output_oe &&
    !$past(clock_output_oe) |-> !clock_output_pin)
    else $error("clock output toggles while released");
  contrd_mirror_a: assert property (mode_wr |-> ##[0:2]
    cont_read_active == wd_q[2]) else $error("continuous read flag wrong");
  standby_pd_a: assert property (mode_wr |-> ##[0:2]
    analog_power_down == (wd_q[7:5] == 3'h3))
    else $error("power down does not follow mode");
  write_rdy_a: assert property (mode_wr |-> ##[0:1] rdy_n)
    else $error("ready pin not raised by mode write");
  reset_idle_a: assert property ($fell(reset) |->
    rdy_n && !analog_power_down) else $error("not idle after reset");
  standby_quiet_a: assert property (analog_power_down &&
    $past(analog_power_down) |-> !$fell(rdy_n))
    else $error("completion during standby");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response lost");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data lost");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
endmodule
bind ams_mode_sequencer ams_checker chk_u (
  .clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .clock_output_pin,
  .clock_output_oe, .rdy_n, .analog_power_down, .cont_read_active
);
`default_nettype wire

// >>> tb/ams_front_model.sv
`default_nettype none
module ams_front_model (
  input wire logic clk_sys,
  input wire logic [1:0] mux_channel,
  output logic clock_input_pin,
  output logic [23:0] conv_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_q = 3'h0;
  // Master clock runs free at 200 ns, stepped from clk_sys edges
  always @(posedge clk_sys) begin
    div_q <= div_q + 3'h1;
  end
  assign clock_input_pin = div_q[2];
  // Channel number sits in the result so a wrong mux shows up in the data
  assign conv_sample = {6'h2b, mux_channel, 16'h9e71};
endmodule
`default_nettype wire

// >>> tb/ams_mode_sequencer_tb.sv
`default_nettype none
module ams_mode_sequencer_tb import ams_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [AW-1:0] s_axi_awaddr = '0;
  logic [AW-1:0] s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, mux_channel, input_source, rsp;
  logic clock_input_pin, clock_output_pin, clock_output_oe;
  logic crystal_mode = 1'b0, conv_over_hi = 1'b0, conv_over_lo = 1'b0;
  logic rdy_n, analog_power_down, cont_read_active;
  logic [23:0] conv_sample;
  int miscompares = 0;
  int num_checks = 0;

  ams_mode_sequencer dut_u (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .clock_input_pin, .crystal_mode,
    .clock_output_pin, .clock_output_oe, .rdy_n, .conv_sample,
    .conv_over_hi, .conv_over_lo, .analog_power_down, .mux_channel,
    .input_source, .cont_read_active);
  ams_front_model far_u (.clk_sys, .mux_channel, .clock_input_pin,
    .conv_sample);

  always #12.5 clk_sys = ~clk_sys;

  function automatic logic [23:0] smp(input logic [1:0] c);
    return {6'h2b, c, 16'h9e71};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t saw %h want %h", $time, s, e);
    end
  endtask

  // Ready is raised only after the answer shows, so the hold path is used
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      s_axi_bready <= s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    chk(32'(n < 100), 32'h1);
    chk(32'(s_axi_bresp), 32'(RESP_OKAY));
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      s_axi_rready <= s_axi_rvalid;
    end
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(32'(n < 100), 32'h1);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
    chk(32'(rsp), 32'(RESP_OKAY));
  endtask

  // Skip two edges first: the pin may still show the previous result
  task automatic wrdy(input logic e);
    int n;
    repeat (2) @(posedge clk_sys);
    for (n = 0; n < 400 && rdy_n !== 1'b0; n++) @(posedge clk_sys);
    chk(32'(rdy_n), 32'(!e));
  endtask

  task automatic t_reset;
    rc(8'he0, 32'h0);
    chk(32'(rdy_n), 32'h1);
    rc(8'h04, 32'h1);
    rd(8'h08);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(8'hec, 32'h01);
    rc(8'he0, 32'h01);
    rc(8'hec, 32'h0);
  endtask

  task automatic t_single;
    wr(8'he8, 32'h42);
    wrdy(1'b1);
    rc(8'h00, 32'h04);
    rc(8'he0, 32'h02);
    rc(8'h28, 32'h82);
    rc(8'h38, {8'h0, smp(2'h2)});
    repeat (2) @(posedge clk_sys);
    chk(32'(rdy_n), 32'h1);
  endtask

  task automatic t_clamp;
    logic [7:0] m[3] = '{8'h41, 8'h41, 8'h40};
    logic [1:0] ov[3] = '{2'b10, 2'b01, 2'b10};
    logic [23:0] ex[3] = '{24'h00ffff, 24'h0, 24'h00ad9e};
    for (int i = 0; i < 3; i++) begin
      {conv_over_hi, conv_over_lo} <= ov[i];
      wr(8'he4, {24'h0, m[i]});
      wrdy(1'b1);
      rc(8'h34, {8'h0, ex[i]});
    end
    {conv_over_hi, conv_over_lo} <= 2'b00;
  endtask

  task automatic t_dump;
    logic [7:0] m[2] = '{8'h4a, 8'h46};
    for (int i = 0; i < 2; i++) begin
      wr(8'he0, {24'h0, m[i]});
      wrdy(1'b1);
      chk(32'(cont_read_active), 32'(m[i][2]));
      rc(8'h20, {8'h80, smp(2'h0)});
      rc(8'h30, {8'h80, smp(2'h0)});
    end
  endtask

  task automatic t_cal;
    logic [7:0] ca[4] = '{8'h40, 8'h44, 8'h54, 8'h64};
    logic [1:0] src[4] = '{SRC_SHORTED, SRC_FULL_REF, SRC_CHANNEL,
                           SRC_CHANNEL};
    for (int i = 0; i < 4; i++) begin
      wr(8'he4, {24'h0, 3'(i + 4), 5'h02});
      chk(32'(input_source), 32'(src[i]));
      chk(32'(mux_channel), 32'h1);
      wrdy(1'b1);
      rc(8'h00, 32'h0f);
      rc(8'he0, 32'h02);
      rc(ca[i], {8'h0, smp(2'h1)});
    end
  endtask

  task automatic t_cont;
    int n;
    logic [1:0] seen;
    wr(8'h04, 32'h3);
    wr(8'he0, 32'h22);
    rdv = '0;
    for (n = 0; n < 100 && rdv[3:0] !== 4'h3; n++) rd(8'h00);
    chk(rdv, 32'h33);
    rc(8'h30, {8'h0, smp(2'h0)});
    rc(8'h34, {8'h0, smp(2'h1)});
    wrdy(1'b1);
    wr(8'he0, 32'h60);
    rc(8'h00, 32'h70);
    chk(32'(rdy_n), 32'h1);
    chk(32'(analog_power_down), 32'h1);
    chk(32'(clock_output_oe), 32'h1);
    seen = 2'b00;
    repeat (10) begin
      @(posedge clk_sys);
      seen[clock_output_pin] = 1'b1;
    end
    chk(32'(seen), 32'h3);
    wr(8'he0, 32'h70);
    repeat (3) @(posedge clk_sys);
    chk(32'(clock_output_oe), 32'h0);
    crystal_mode <= 1'b1;
    wr(8'he8, 32'h52);
    wrdy(1'b0);
    rc(8'h00, 32'h50);
    crystal_mode <= 1'b0;
    wr(8'he8, 32'h52);
    wrdy(1'b1);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_reset();
    for (int i = 0; i < 4; i++) wr(8'h10 + 8'(4 * i), 32'h4);
    t_single();
    t_clamp();
    t_dump();
    t_cal();
    t_cont();
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
